// [verilog/bsr_defs.vh]
`ifndef BSR_DEFS_VH
`define BSR_DEFS_VH

`define BSR_CLK_HZ        20000000
`define BSR_RELEASE_MS    200
`define BSR_BLANK_US      50
`define BSR_SOFTSTART_US  2600

`define BSR_ADDR_W        12
`define BSR_OFF_CTRL      12'h000
`define BSR_OFF_STATUS    12'h004

`define BSR_CTRL_SEQ_BIT  0
`define BSR_CTRL_RST      32'h00000000

`define BSR_DLIM_SUSPEND  2'h3

`define BSR_MASK_OFF      3'h0
`define BSR_MASK_C        3'h4
`define BSR_MASK_CB       3'h6
`define BSR_MASK_CBA      3'h7

`endif

// [verilog/bsr_rail.v]
`timescale 1ns/1ps
`include "bsr_defs.vh"

module bsr_rail #(
  parameter SS_CYCLES = `BSR_SOFTSTART_US * (`BSR_CLK_HZ / 1000000),
  parameter CW        = 16
) (
  input  wire clk,
  input  wire rstn,
  input  wire rail_on,
  input  wire vin_ok,
  input  wire sc_low,
  output reg  ss_done_r,
  output reg  foldback_r,
  output reg  discharge_r
);

  localparam [31:0]   SS_CYC  = SS_CYCLES - 1;
  localparam [CW-1:0] SS_LAST = SS_CYC[CW-1:0];

  reg [CW-1:0] ss_cnt_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ss_cnt_r    <= {CW{1'b0}};
      ss_done_r   <= 1'b0;
      foldback_r  <= 1'b0;
      discharge_r <= 1'b0;
    end else begin
      if (!rail_on) begin
        ss_cnt_r  <= {CW{1'b0}};
        ss_done_r <= 1'b0;
      end else if (!ss_done_r) begin
        if (ss_cnt_r == SS_LAST)
          ss_done_r <= 1'b1;
        else
          ss_cnt_r <= ss_cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
      // Ignored during soft-start, when the output is legitimately low
      foldback_r  <= rail_on & ss_done_r & sc_low;
      // Below 1V input the switch cannot be driven, so it stays open
      discharge_r <= vin_ok & ~rail_on;
    end
  end

endmodule

// [verilog/bsr_sequencer.v]
`timescale 1ns/1ps
`include "bsr_defs.vh"

module bsr_sequencer #(
  parameter SEQ_DEFAULT    = 1'b0,
  parameter RELEASE_CYCLES = `BSR_RELEASE_MS * (`BSR_CLK_HZ / 1000),
  parameter STEP_CYCLES    = `BSR_SOFTSTART_US * (`BSR_CLK_HZ / 1000000),
  parameter REL_W          = 22,
  parameter STEP_W         = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        buck_group_enable,
  input  wire        backlight_enable,
  input  wire        charge_enable,
  input  wire        rail_a_feedback_ok,
  input  wire [2:0]  rail_fb_short,
  input  wire        dc_valid,
  input  wire [1:0]  input_limit_select,
  input  wire        dc_suspend,
  input  wire        sys_ok,
  input  wire        vin_above_1v0,
  output reg         core_reset_out_n,
  output reg         core_reset_oe_n,
  output reg         charge_indicator,
  output reg         charge_indicator_oe_n,
  output reg         buck_rail_a_en,
  output reg         buck_rail_b_en,
  output reg         buck_rail_c_en,
  output wire        rail_a_foldback,
  output wire        rail_b_foldback,
  output wire        rail_c_foldback,
  output wire        rail_a_discharge,
  output wire        rail_b_discharge,
  output wire        rail_c_discharge,
  output reg         charger_en,
  output reg         sys_from_dc,
  output reg         boost_backlight_rail_en
);

  localparam [31:0]       BLANK_CYC  = `BSR_BLANK_US * (`BSR_CLK_HZ / 1000000) - 1;
  localparam [31:0]       REL_CYC    = RELEASE_CYCLES - 1;
  localparam [31:0]       STEP_CYC   = STEP_CYCLES - 1;
  localparam [9:0]        BLANK_LAST = BLANK_CYC[9:0];
  localparam [REL_W-1:0]  REL_LAST   = REL_CYC[REL_W-1:0];
  localparam [STEP_W-1:0] STEP_LAST  = STEP_CYC[STEP_W-1:0];

  localparam [3:0] S_OFF = 4'b0001;
  localparam [3:0] S_C   = 4'b0010;
  localparam [3:0] S_CB  = 4'b0100;
  localparam [3:0] S_CBA = 4'b1000;

  localparam SYNC_W = 13;

  // Pin synchroniser; only the second stage is read by logic
  reg  [SYNC_W-1:0] sync1_r;
  reg  [SYNC_W-1:0] sync2_r;
  wire [SYNC_W-1:0] pins_in;

  assign pins_in = {vin_above_1v0, sys_ok, dc_suspend, input_limit_select, dc_valid,
                    rail_fb_short, rail_a_feedback_ok, charge_enable, backlight_enable,
                    buck_group_enable};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= {SYNC_W{1'b0}};
      sync2_r <= {SYNC_W{1'b0}};
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
    end
  end

  wire       grp_en_s  = sync2_r[0];
  wire       bl_en_s   = sync2_r[1];
  wire       chg_en_s  = sync2_r[2];
  wire       fb_ok_s   = sync2_r[3];
  wire [2:0] short_s   = sync2_r[6:4];
  wire       dc_val_s  = sync2_r[7];
  wire [1:0] dlim_s    = sync2_r[9:8];
  wire       susp_s    = sync2_r[10];
  wire       sys_ok_s  = sync2_r[11];
  wire       vin_ok_s  = sync2_r[12];

  // Software-held control
  reg  [31:0] ctrl_r;
  wire        seq_mode = ctrl_r[`BSR_CTRL_SEQ_BIT];

  // Input supply qualification
  wire dc_suspended = seq_mode ? susp_s : (dlim_s == `BSR_DLIM_SUSPEND);
  wire dc_ok        = dc_val_s & ~dc_suspended;

  // Non-sequenced parts power the bucks from a good input as well as the pin
  wire rails_wanted = grp_en_s | (~seq_mode & dc_ok);

  // Rail sequencer
  reg  [3:0]        seq_state_r;
  reg  [3:0]        seq_state_nxt;
  reg  [STEP_W-1:0] step_cnt_r;
  reg  [2:0]        rail_mask_nxt;
  reg               grp_en_d_r;
  wire              step_done = (step_cnt_r == STEP_LAST);

  always @* begin
    seq_state_nxt = seq_state_r;
    case (seq_state_r)
      S_OFF: begin
        if (grp_en_s)
          seq_state_nxt = S_C;
      end
      S_C: begin
        // C is held a full step so the rails drop together only when sys_ok is lost or seq_mode is clear
        if (!grp_en_s && step_done)
          seq_state_nxt = S_OFF;
        else if (grp_en_s && step_done)
          seq_state_nxt = S_CB;
      end
      S_CB: begin
        if (!grp_en_s && step_done)
          seq_state_nxt = S_C;
        else if (grp_en_s && step_done)
          seq_state_nxt = S_CBA;
      end
      S_CBA: begin
        if (!grp_en_s)
          seq_state_nxt = S_CB;
      end
      default: seq_state_nxt = S_OFF;
    endcase
    if (!sys_ok_s || !seq_mode)
      seq_state_nxt = S_OFF;
  end

  always @* begin
    case (seq_state_r)
      S_C:     rail_mask_nxt = `BSR_MASK_C;
      S_CB:    rail_mask_nxt = `BSR_MASK_CB;
      S_CBA:   rail_mask_nxt = `BSR_MASK_CBA;
      default: rail_mask_nxt = `BSR_MASK_OFF;
    endcase
    if (!seq_mode)
      rail_mask_nxt = rails_wanted ? `BSR_MASK_CBA : `BSR_MASK_OFF;
    if (!sys_ok_s)
      rail_mask_nxt = `BSR_MASK_OFF;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_state_r    <= S_OFF;
      step_cnt_r     <= {STEP_W{1'b0}};
      buck_rail_a_en <= 1'b0;
      buck_rail_b_en <= 1'b0;
      buck_rail_c_en <= 1'b0;
      grp_en_d_r     <= 1'b0;
    end else begin
      seq_state_r <= seq_state_nxt;
      // Each step waits one soft-start time so the previous rail is up
      if (seq_state_nxt != seq_state_r || step_done)
        step_cnt_r <= {STEP_W{1'b0}};
      else
        step_cnt_r <= step_cnt_r + {{(STEP_W-1){1'b0}}, 1'b1};
      buck_rail_c_en <= rail_mask_nxt[2];
      buck_rail_b_en <= rail_mask_nxt[1];
      buck_rail_a_en <= rail_mask_nxt[0];
      grp_en_d_r     <= grp_en_s;
    end
  end

  // Per-rail soft-start, fold-back and discharge
  wire [2:0] rail_on = {buck_rail_c_en, buck_rail_b_en, buck_rail_a_en};
  wire [2:0] fold_w;
  wire [2:0] dis_w;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_rail
      bsr_rail #(
        .SS_CYCLES (STEP_CYCLES),
        .CW        (STEP_W)
      ) u_rail (
        .clk         (pclk),
        .rstn        (presetn),
        .rail_on     (rail_on[gi]),
        .vin_ok      (vin_ok_s),
        .sc_low      (short_s[gi]),
        .ss_done_r   (),
        .foldback_r  (fold_w[gi]),
        .discharge_r (dis_w[gi])
      );
    end
  endgenerate

  assign rail_a_foldback  = fold_w[0];
  assign rail_b_foldback  = fold_w[1];
  assign rail_c_foldback  = fold_w[2];
  assign rail_a_discharge = dis_w[0];
  assign rail_b_discharge = dis_w[1];
  assign rail_c_discharge = dis_w[2];

  // Core reset supervisor
  reg             rst_asserted_r;
  reg [REL_W-1:0] rel_cnt_r;
  reg [9:0]       blank_cnt_r;
  wire            grp_fall = grp_en_d_r & ~grp_en_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_asserted_r <= 1'b1;
      rel_cnt_r      <= {REL_W{1'b0}};
      blank_cnt_r    <= 10'h000;
    end else if (!sys_ok_s) begin
      rst_asserted_r <= 1'b1;
      rel_cnt_r      <= {REL_W{1'b0}};
      blank_cnt_r    <= 10'h000;
    end else if (grp_en_s) begin
      rst_asserted_r <= 1'b0;
      rel_cnt_r      <= {REL_W{1'b0}};
      blank_cnt_r    <= 10'h000;
    end else if (grp_fall) begin
      rst_asserted_r <= 1'b1;
      rel_cnt_r      <= {REL_W{1'b0}};
      blank_cnt_r    <= 10'h000;
    end else if (fb_ok_s) begin
      blank_cnt_r <= 10'h000;
      if (rst_asserted_r) begin
        if (rel_cnt_r == REL_LAST)
          rst_asserted_r <= 1'b0;
        else
          rel_cnt_r <= rel_cnt_r + {{(REL_W-1){1'b0}}, 1'b1};
      end
    end else begin
      // A dip during the release delay starts the wait over
      rel_cnt_r <= {REL_W{1'b0}};
      if (!rst_asserted_r) begin
        // Short dips from feedback retuning must not reach the host
        if (blank_cnt_r == BLANK_LAST) begin
          rst_asserted_r <= 1'b1;
          blank_cnt_r    <= 10'h000;
        end else begin
          blank_cnt_r <= blank_cnt_r + 10'h001;
        end
      end
    end
  end

  // Open-drain reset: level always low, enable low while pulling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_out_n <= 1'b0;
      core_reset_oe_n  <= 1'b0;
    end else begin
      core_reset_out_n <= 1'b0;
      core_reset_oe_n  <= ~rst_asserted_r;
    end
  end

  // Charger, input switch and backlight
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charger_en              <= 1'b0;
      charge_indicator        <= 1'b0;
      charge_indicator_oe_n   <= 1'b1;
      sys_from_dc             <= 1'b0;
      boost_backlight_rail_en <= 1'b0;
    end else begin
      charger_en              <= chg_en_s & dc_ok & sys_ok_s;
      charge_indicator        <= 1'b0;
      charge_indicator_oe_n   <= ~(chg_en_s & dc_ok & sys_ok_s);
      sys_from_dc             <= dc_ok;
      boost_backlight_rail_en <= bl_en_s & sys_ok_s;
    end
  end

  // APB slave: one access cycle, no wait states
  wire setup_ph  = psel & ~penable;
  wire access_ok = psel & penable & pready;
  wire hit_ctrl  = (paddr == `BSR_OFF_CTRL);
  wire hit_stat  = (paddr == `BSR_OFF_STATUS);

  wire [31:0] status_w = {15'h0000, seq_state_r, dis_w, fold_w, rail_on,
                          charger_en, dc_ok, sys_ok_s, rst_asserted_r};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= `BSR_CTRL_RST | {31'h00000000, SEQ_DEFAULT};
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (setup_ph) begin
        pready  <= 1'b1;
        pslverr <= ~(hit_ctrl | hit_stat);
        if (pwrite)
          prdata <= 32'h00000000;
        else if (hit_ctrl)
          prdata <= ctrl_r;
        else if (hit_stat)
          prdata <= status_w;
        else
          prdata <= 32'h00000000;
      end else if (access_ok) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        // Only the sequencing bit is writable; the rest reads zero
        if (pwrite && hit_ctrl)
          ctrl_r <= {31'h00000000, pwdata[`BSR_CTRL_SEQ_BIT]};
      end
    end
  end

endmodule

// [tb/bsr_chk_sva.sv]
`timescale 1ns/1ps
module bsr_chk #(
  parameter REL = 40
) (
  input wire pclk,
  input wire presetn,
  input wire buck_group_enable,
  input wire sys_ok,
  input wire dc_valid,
  input wire rail_a_feedback_ok,
  input wire core_reset_oe_n,
  input wire charger_en,
  input wire charge_indicator_oe_n,
  input wire buck_rail_a_en
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [15:0] lo;
  reg [15:0] hi;
  reg [3:0]  gq;
  // Run lengths are taken at the pins, so every bound allows for the synchroniser delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo <= 16'h0;
      hi <= 16'h0;
      gq <= 4'h0;
    end else begin
      lo <= (rail_a_feedback_ok || buck_group_enable || !sys_ok) ? 16'h0 : lo + {15'h0, ~&lo};
      hi <= (!rail_a_feedback_ok || buck_group_enable || !sys_ok) ? 16'h0 : hi + {15'h0, ~&hi};
      gq <= buck_group_enable ? 4'h0 : gq + {3'h0, ~&gq};
    end
  end
  property p_fb_low;
    lo == 16'h03f2 |-> !core_reset_oe_n;
  endproperty
  a_fb_low: assert property (p_fb_low) else $error("reset missing");
  property p_blank;
    lo > 16'h0005 && lo < 16'h03e3 |-> !$fell(core_reset_oe_n);
  endproperty
  a_blank: assert property (p_blank) else $error("blanking broken");
  property p_hold;
    hi == REL + 8 |-> core_reset_oe_n;
  endproperty
  a_hold: assert property (p_hold) else $error("release late");
  property p_rise;
    $rose(core_reset_oe_n) && gq > 4'h8 |-> hi >= REL;
  endproperty
  a_rise: assert property (p_rise) else $error("release early");
  property p_grp_rel;
    (buck_group_enable && sys_ok)[*5] |=> core_reset_oe_n;
  endproperty
  a_grp_rel: assert property (p_grp_rel) else $error("reset under enable");
  property p_grp_fall;
    $fell(buck_group_enable) |-> ##[1:5] !core_reset_oe_n;
  endproperty
  a_grp_fall: assert property (p_grp_fall) else $error("no reset on off");
  property p_sys_low;
    (!sys_ok)[*5] |=> !core_reset_oe_n && !buck_rail_a_en && !charger_en;
  endproperty
  a_sys_low: assert property (p_sys_low) else $error("system low ignored");
  property p_dc_gone;
    (!dc_valid)[*5] |=> !charger_en && charge_indicator_oe_n;
  endproperty
  a_dc_gone: assert property (p_dc_gone) else $error("charging without input");
  c_blank: cover property (lo == 16'h03f2);
  c_rise: cover property ($rose(core_reset_oe_n));
  c_seq: cover property (buck_rail_a_en && buck_group_enable);
endmodule

// [tb/bsr_host.sv]
`timescale 1ns/1ps
module bsr_host (
  input  wire pclk,
  input  wire reset_line,
  input  wire boot,
  input  wire off,
  output reg  grp_en,
  output reg  bl_en,
  output reg  chg_en
);
  initial {grp_en, bl_en, chg_en} = 3'h0;
  // Firmware runs, and so raises its enables, only once reset is seen released
  always @(posedge pclk) begin
    if (off) begin
      {grp_en, bl_en, chg_en} <= 3'h0;
    end else if (boot && reset_line) begin
      {grp_en, bl_en, chg_en} <= 3'h7;
    end
  end
endmodule

// [tb/buck_sequencer_reset_supervisor_test.sv]
`timescale 1ns/1ps
module buck_sequencer_reset_supervisor_test;
  localparam int CG = 0, DS = 1, FD = 2, RL = 3, OE = 4;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        rail_a_feedback_ok = 1'h0, dc_valid = 1'h0, dc_suspend = 1'h0, sys_ok = 1'h1;
  logic        vin_above_1v0 = 1'h1, boot = 1'h0, off = 1'h0;
  logic [2:0]  rail_fb_short = 3'h0;
  logic [1:0]  input_limit_select = 2'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, buck_group_enable, backlight_enable, charge_enable, charger_en, sys_from_dc;
  wire         core_reset_out_n, core_reset_oe_n, charge_indicator_oe_n, buck_rail_a_en, buck_rail_b_en;
  wire         buck_rail_c_en, rail_a_foldback, rail_b_foldback, rail_c_foldback;
  wire         rail_a_discharge, rail_b_discharge, rail_c_discharge, bl_rail_en, chg_ind;
  // Open-drain reset with its pull-up, as the host sees it
  wire         rst_line = core_reset_oe_n ? 1'h1 : core_reset_out_n;
  wire  [14:0] obs = {2'h0, core_reset_oe_n, buck_rail_c_en, buck_rail_b_en, buck_rail_a_en, rail_c_foldback,
                      rail_b_foldback, rail_a_foldback, rail_c_discharge, rail_b_discharge, rail_a_discharge,
                      charger_en, charge_indicator_oe_n, sys_from_dc};
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  bsr_sequencer #(.RELEASE_CYCLES(40), .STEP_CYCLES(20)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .buck_group_enable,
    .backlight_enable, .charge_enable, .rail_a_feedback_ok, .rail_fb_short, .dc_valid, .input_limit_select,
    .dc_suspend, .sys_ok, .vin_above_1v0, .core_reset_out_n, .core_reset_oe_n, .charge_indicator(chg_ind),
    .charge_indicator_oe_n, .buck_rail_a_en, .buck_rail_b_en, .buck_rail_c_en, .rail_a_foldback,
    .rail_b_foldback, .rail_c_foldback, .rail_a_discharge, .rail_b_discharge, .rail_c_discharge, .charger_en,
    .sys_from_dc, .boost_backlight_rail_en(bl_rail_en)
  );
  bsr_host host (.pclk, .reset_line(rst_line), .boot, .off, .grp_en(buck_group_enable),
                 .bl_en(backlight_enable), .chg_en(charge_enable));

  always #25 pclk = ~pclk;

  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic ck(input int n, input int k, input logic [2:0] e);
    repeat (n) @(posedge pclk);
    chk({29'h0, obs[k*3 +: 3]}, {29'h0, e});
  endtask

  task automatic xf(input bit w, input bit [11:0] a, input bit [31:0] d, input bit e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    chk({31'h0, pslverr}, {31'h0, e});
    if (!w) chk(prdata, d);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    ck(3, OE, 3'h0);
    chk({31'h0, core_reset_out_n}, 32'h0);
    xf(0, 12'h0, 32'h0, 0);
    xf(0, 12'h8, 32'h0, 1);
    xf(1, 12'h0, 32'h1, 0);
    xf(0, 12'h0, 32'h1, 0);
    ck(1, DS, 3'h7);
    vin_above_1v0 <= 1'h0;
    ck(6, DS, 3'h0);
    vin_above_1v0 <= 1'h1;
    rail_a_feedback_ok <= 1'h1;
    ck(30, OE, 3'h0);
    ck(20, OE, 3'h1);
    rail_a_feedback_ok <= 1'h0;
    ck(500, OE, 3'h1);
    rail_a_feedback_ok <= 1'h1;
    repeat (10) @(posedge pclk);
    rail_a_feedback_ok <= 1'h0;
    ck(1010, OE, 3'h0);
    rail_a_feedback_ok <= 1'h1;
    repeat (30) @(posedge pclk);
    rail_a_feedback_ok <= 1'h0;
    repeat (5) @(posedge pclk);
    rail_a_feedback_ok <= 1'h1;
    ck(30, OE, 3'h0);
    ck(20, OE, 3'h1);
    boot <= 1'h1;
    ck(12, RL, 3'h4);
    ck(20, RL, 3'h6);
    ck(20, RL, 3'h7);
    chk({31'h0, bl_rail_en}, 32'h1);
    rail_a_feedback_ok <= 1'h0;
    ck(1010, OE, 3'h1);
    rail_a_feedback_ok <= 1'h1;
    rail_fb_short <= 3'h1;
    ck(6, FD, 3'h1);
    rail_fb_short <= 3'h0;
    ck(6, FD, 3'h0);
    dc_valid <= 1'h1;
    ck(6, CG, 3'h5);
    chk({31'h0, chg_ind}, 32'h0);
    dc_suspend <= 1'h1;
    ck(6, CG, 3'h2);
    dc_suspend <= 1'h0;
    ck(6, CG, 3'h5);
    dc_valid <= 1'h0;
    ck(6, CG, 3'h2);
    ck(0, RL, 3'h7);
    boot <= 1'h0;
    off <= 1'h1;
    ck(10, OE, 3'h0);
    ck(0, RL, 3'h6);
    ck(20, RL, 3'h4);
    ck(20, RL, 3'h0);
    ck(6, DS, 3'h7);
    xf(0, 12'h4, 32'h00003c02, 0);
    xf(1, 12'h0, 32'h0, 0);
    dc_valid <= 1'h1;
    input_limit_select <= 2'h3;
    ck(6, CG, 3'h2);
    input_limit_select <= 2'h0;
    ck(6, CG, 3'h3);
    sys_ok <= 1'h0;
    ck(6, RL, 3'h0);
    ck(3, OE, 3'h0);
    finish_test();
  end
endmodule

bind bsr_sequencer bsr_chk #(.REL(RELEASE_CYCLES)) u_chk (
  .pclk, .presetn, .buck_group_enable, .sys_ok, .dc_valid, .rail_a_feedback_ok, .core_reset_oe_n,
  .charger_en, .charge_indicator_oe_n, .buck_rail_a_en
);
